// file: src/ees_slave.sv
// Purpose: Two-wire slave of a 2048-byte EEPROM with 16-byte page buffer.
// Assumes: Master owns SCL and all START/STOP; SCL may stop between frames.
// Notes: Bits are caught on SCL; framing and memory run on sys_clk.
//
// Notes on behaviour
// - SDA stays steady while SCL high; changes then are START or STOP.
// - START is SDA falling with SCL high; silent until START seen.
// - STOP is SDA rising with SCL high.
// - Upper four bits of first byte must be 1010 or device ignores.
// - Next three bits of first byte are the top memory address bits.
// - Last bit of first byte: one reads, zero writes.
// - Matching first byte is acknowledged, then the transfer runs.
// - Receiver acknowledges by pulling SDA low on the ninth clock.
// - In a write every received byte is acknowledged, except a data byte while write protect is set.
// - Read sends eight bits, releases, continues on ack, else waits STOP.
// - STOP after write starts programming; no answers until done.
// - Page write takes up to sixteen bytes, programmed in one cycle.
// - Each written data byte increments only low address bits.
// - More than sixteen bytes wrap in page, overwriting earlier ones.
// - Polling address byte is not acknowledged while programming.
// - Write protect: ack addresses, nack first data byte, no programming.
// - Address counter is last accessed plus one, wrapping at top.
// - Current address read returns byte at counter; master nacks, STOPs.
// - Supervisor reset active: accesses ignored, no acknowledge.
// - Programming cycle lasts no more than ten milliseconds.
// - Master ack continues reads from successive addresses.
// - Write protect low allows normal reading and writing.
`timescale 1ns/100ps
`include "ees_consts.svh"

module ees_slave import ees_pkg::*; #(
  parameter int WR_CYC = `EES_WR_CYC
) (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl,
  // Serial data, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Protection and status
  input wire logic wp,
  input wire logic sup_rst,
  output logic prog_busy
);

  // ****************************************
  // Link domain: bits caught on SCL rise
  // ****************************************
  ees_link_t lnk_r;
  ees_link_t lnk_nxt;

  always_comb begin
    lnk_nxt = lnk_r;
    lnk_nxt.bit_val = sda_i;
    lnk_nxt.tgl = ~lnk_r.tgl;
  end

  // Bit stays put until the next SCL rise, long after the toggle lands
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // ****************************************
  // System domain
  // ****************************************
  ees_sys_t s_r;
  ees_sys_t s_nxt;
  logic [7:0] mem [0:`EES_MEM_BYTES-1];
  logic [7:0] mem_rd;
  logic mem_we;
  logic [`EES_ADDR_W-1:0] mem_waddr;
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic bit_ev;
  logic byte_done;
  logic do_load;
  logic [7:0] rx_byte;

  assign start_ev = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
  assign stop_ev = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
  assign fall_ev = ~s_r.scl_s & s_r.scl_p;
  assign bit_ev = s_r.tg_s ^ s_r.tg_p;
  assign rx_byte = {s_r.shreg[6:0], lnk_r.bit_val};
  assign byte_done = bit_ev && (s_r.state == S_RX) && (s_r.bit_cnt == 4'h7);
  assign mem_rd = mem[s_r.addr];
  assign mem_waddr = {s_r.addr[`EES_ADDR_W-1:`EES_PAGE_W], s_r.prog_idx[3:0]};
  assign mem_we = s_r.busy && !s_r.prog_idx[4] && s_r.pg_val[s_r.prog_idx[3:0]];

  always_comb begin
    s_nxt = s_r;
    do_load = 1'b0;
    s_nxt.scl_m = scl;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_i;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    s_nxt.wp_m = wp;
    s_nxt.wp_s = s_r.wp_m;
    s_nxt.rst_m = sup_rst;
    s_nxt.rst_s = s_r.rst_m;
    s_nxt.tg_m = lnk_r.tgl;
    s_nxt.tg_s = s_r.tg_m;
    s_nxt.tg_p = s_r.tg_s;
    // One byte per cycle, then wait out the rest of the cycle time
    if (s_r.busy) begin
      if (!s_r.prog_idx[4]) begin
        s_nxt.prog_idx = s_r.prog_idx + 5'h01;
      end
      s_nxt.tmr = s_r.tmr + 32'h1;
      if (s_r.tmr == WR_CYC - 1) begin
        s_nxt.busy = 1'b0;
        s_nxt.pg_val = '0;
      end
    end
    unique case (s_r.state)
      S_IDLE: begin
      end
      S_RX: begin
        if (bit_ev) begin
          s_nxt.shreg = rx_byte;
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
          if (s_r.bit_cnt == 4'h7) begin
            s_nxt.bit_cnt = 4'h0;
            s_nxt.state = S_ACKW;
            unique case (s_r.kind)
              K_DEV: begin
                if (rx_byte[7:4] != `EES_DEV_TYPE) begin
                  s_nxt.state = S_IDLE;
                end else begin
                  s_nxt.addr[`EES_ADDR_W-1:8] = rx_byte[3:1];
                  s_nxt.rd = rx_byte[0];
                end
              end
              K_WORD: begin
                s_nxt.addr[7:0] = rx_byte;
                s_nxt.pg_val = '0;
              end
              default: begin
                if (s_r.wp_s) begin
                  s_nxt.state = S_IDLE;
                end else begin
                  // Repeat writes to a slot replace the older byte
                  s_nxt.pg_buf[s_r.addr[3:0]] = rx_byte;
                  s_nxt.pg_val[s_r.addr[3:0]] = 1'b1;
                  s_nxt.addr[3:0] = s_r.addr[3:0] + 4'h1;
                end
              end
            endcase
          end
        end
      end
      S_ACKW: begin
        if (fall_ev) begin
          s_nxt.drv = 1'b1;
          s_nxt.state = S_ACKH;
        end
      end
      S_ACKH: begin
        if (fall_ev) begin
          s_nxt.drv = 1'b0;
          s_nxt.state = S_RX;
          if (s_r.kind == K_DEV && s_r.rd) begin
            do_load = 1'b1;
          end else if (s_r.kind == K_DEV) begin
            s_nxt.kind = K_WORD;
          end else begin
            s_nxt.kind = K_DATA;
          end
        end
      end
      S_TX: begin
        if (bit_ev) begin
          s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
        end
        if (fall_ev) begin
          if (s_r.bit_cnt == 4'h8) begin
            s_nxt.drv = 1'b0;
            s_nxt.state = S_TXACK;
            s_nxt.bit_cnt = 4'h0;
          end else begin
            s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
            s_nxt.drv = ~s_r.shreg[6];
          end
        end
      end
      S_TXACK: begin
        if (bit_ev) begin
          s_nxt.state = lnk_r.bit_val ? S_IDLE : S_TXLD;
        end
      end
      S_TXLD: begin
        if (fall_ev) begin
          do_load = 1'b1;
        end
      end
    endcase
    if (do_load) begin
      s_nxt.shreg = mem_rd;
      s_nxt.drv = ~mem_rd[7];
      s_nxt.addr = s_r.addr + 11'h001;
      s_nxt.state = S_TX;
      s_nxt.bit_cnt = 4'h0;
    end
    if (start_ev) begin
      s_nxt.drv = 1'b0;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.kind = K_DEV;
      // Busy device stays deaf so polling sees no acknowledge
      s_nxt.state = (s_r.busy || s_r.rst_s) ? S_IDLE : S_RX;
    end
    if (stop_ev) begin
      s_nxt.drv = 1'b0;
      s_nxt.state = S_IDLE;
      if ((s_r.pg_val != '0) && !s_r.busy && !s_r.rst_s && !s_r.wp_s) begin
        s_nxt.busy = 1'b1;
        s_nxt.prog_idx = 5'h00;
        s_nxt.tmr = 32'h0;
      end
    end
    // Supply lockout drops any partial page
    if (s_r.rst_s) begin
      s_nxt.state = S_IDLE;
      s_nxt.drv = 1'b0;
      s_nxt.pg_val = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Array has no reset; content is nonvolatile in spirit
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= s_r.pg_buf[s_r.prog_idx[3:0]];
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = ~s_r.drv;
  assign prog_busy = s_r.busy;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_silent_idle: assert property (s_r.state == S_IDLE |-> sda_oe_n)
    else $error("SDA driven while idle");
  a_stop_idle: assert property (stop_ev && !s_r.rst_s |=> s_r.state == S_IDLE)
    else $error("STOP did not end the frame");
  a_start_rx: assert property (start_ev && !s_r.busy && !s_r.rst_s
    |=> s_r.state == S_RX && s_r.kind == K_DEV && s_r.bit_cnt == 4'h0)
    else $error("START not taken");
  a_dev_match: assert property (byte_done && s_r.kind == K_DEV
    && s_r.shreg[6:3] != `EES_DEV_TYPE && !start_ev && !stop_ev
    |=> s_r.state == S_IDLE)
    else $error("Foreign address accepted");
  a_wp_nack: assert property (byte_done && s_r.kind == K_DATA && s_r.wp_s
    && !start_ev && !stop_ev |=> s_r.state == S_IDLE && $stable(s_r.pg_val))
    else $error("Protected data byte taken");
  a_page_wrap: assert property (byte_done && s_r.kind == K_DATA && !s_r.wp_s && !s_r.rst_s
    |=> s_r.addr[10:4] == $past(s_r.addr[10:4])
    && s_r.addr[3:0] == 4'($past(s_r.addr[3:0]) + 4'h1))
    else $error("Page address step wrong");
  a_ack_low: assert property (s_r.state == S_ACKH && !fall_ev |=> !sda_oe_n
    || s_r.state != S_ACKH)
    else $error("Acknowledge not driven");
  a_busy_deaf: assert property (s_r.busy |-> sda_oe_n)
    else $error("Answer during programming");
  a_rst_quiet: assert property (s_r.rst_s |=> sda_oe_n && s_r.state == S_IDLE)
    else $error("Answer during supervisor reset");
  a_prog_start: assert property (stop_ev && s_r.pg_val != '0 && !s_r.busy
    && !s_r.rst_s && !s_r.wp_s |=> s_r.busy && s_r.tmr == 32'h0)
    else $error("Programming did not start");
  a_prog_end: assert property (s_r.busy && s_r.tmr == WR_CYC - 1 |=> !s_r.busy)
    else $error("Programming overran");
  a_tx_incr: assert property (do_load |=> s_r.state == S_TX
    && s_r.addr == 11'($past(s_r.addr) + 11'h001))
    else $error("Read counter did not advance");
  a_addr_bits: assert property (byte_done && s_r.kind == K_DEV
    && rx_byte[7:4] == `EES_DEV_TYPE |=> s_r.addr[`EES_ADDR_W-1:8] == $past(rx_byte[3:1])
    && s_r.rd == $past(rx_byte[0]))
    else $error("Address byte fields not taken");
  a_tx_release: assert property (s_r.state == S_TX && fall_ev
    && s_r.bit_cnt == 4'h8 && !s_r.rst_s |=> sda_oe_n && s_r.state == S_TXACK)
    else $error("Data line not released after eight bits");
  a_nack_idle: assert property (s_r.state == S_TXACK && bit_ev && lnk_r.bit_val
    && !start_ev && !s_r.rst_s |=> s_r.state == S_IDLE)
    else $error("Read went on without acknowledge");

endmodule : ees_slave

// file: common/ees_consts.svh
// Purpose: Shared constants of the serial EEPROM slave.
// Assumes: System clock of 250 MHz.
// Notes: Counts derive from times; longest times round down.
`ifndef EES_CONSTS_SVH
`define EES_CONSTS_SVH

`define EES_DEV_TYPE 4'hA
`define EES_ADDR_W 11
`define EES_MEM_BYTES 2048
`define EES_PAGE_BYTES 16
`define EES_PAGE_W 4
`define EES_CLK_NS 4
`define EES_T_WR_MS 10
`define EES_WR_CYC ((`EES_T_WR_MS * 1000000) / `EES_CLK_NS)

`endif

// file: common/ees_pkg.sv
// Purpose: Types of the serial EEPROM slave.
// Assumes: ees_consts.svh on the include path.
// Notes: Whole state of each clock domain, but for the memory array, is one packed struct.
`include "ees_consts.svh"

package ees_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_ACKW, S_ACKH, S_TX, S_TXACK, S_TXLD
  } ees_state_t;

  typedef enum logic [1:0] {
    K_DEV, K_WORD, K_DATA
  } ees_kind_t;

  typedef struct packed {
    logic bit_val;
    logic tgl;
  } ees_link_t;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic wp_m;
    logic wp_s;
    logic rst_m;
    logic rst_s;
    logic tg_m;
    logic tg_s;
    logic tg_p;
    ees_state_t state;
    ees_kind_t kind;
    logic drv;
    logic rd;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [`EES_ADDR_W-1:0] addr;
    logic [`EES_PAGE_BYTES-1:0] pg_val;
    logic [`EES_PAGE_BYTES-1:0][7:0] pg_buf;
    logic busy;
    logic [4:0] prog_idx;
    logic [31:0] tmr;
  } ees_sys_t;

endpackage : ees_pkg

// file: dv/ees_bus_master.sv
// Purpose: Bus master model for the serial EEPROM slave.
// Assumes: SDA pulled up outside; SCL period 80 ns.
// Notes: SCL stands high between frames.
`timescale 1ns/100ps

module ees_bus_master (
  // Bus lines
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // ****************
  // Frame primitives
  // ****************
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // Data moves only in the SCL low phase
  task automatic bit_x(input logic b, output logic r);
    #20 sda_m = b;
    #20 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask : bit_x

  // Caller starts only from idle or as repeated start
  task automatic start();
    #20 sda_m = 1'b1;
    #20 scl = 1'b1;
    #20 sda_m = 1'b0;
    #20 scl = 1'b0;
  endtask : start

  task automatic stop();
    #20 sda_m = 1'b0;
    #20 scl = 1'b1;
    #20 sda_m = 1'b1;
    #20;
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(~ack, r);
  endtask : rbyte
endmodule : ees_bus_master

// file: dv/ees_slave_tb.sv
// Purpose: Self-checking bench of the serial EEPROM slave.
// Assumes: Short programming count, long enough to poll once.
// Notes: SDA is a wired AND of master and slave.
`timescale 1ns/100ps

module ees_slave_tb;
  // *****
  // Setup
  // *****
  localparam int WCYC = 400;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b1;
  logic wp = 1'b0;
  logic sup_rst = 1'b0;
  logic scl, sda_m, sda_o, sda_oe_n, prog_busy, sda;
  logic [7:0] mem_m [0:2047];
  logic [10:0] cnt;
  int err_total = 0;
  int num_checks = 0;

  always #2 sys_clk = ~sys_clk;
  assign sda = sda_m & (sda_oe_n | sda_o);

  ees_slave #(.WR_CYC(WCYC)) dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .scl(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .wp(wp), .sup_rst(sup_rst),
    .prog_busy(prog_busy));
  ees_bus_master mst_u (.scl(scl), .sda_m(sda_m), .sda(sda));

  task automatic final_report();
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_idle();
    int t;
    t = 0;
    while (prog_busy !== 1'b0) begin
      @(posedge sys_clk);
      t++;
      if (t > WCYC + 20) begin
        chk(prog_busy, 8'h00);
        final_report();
      end
    end
  endtask : wait_idle

  // Model page: slot wraps in the low four bits
  task automatic wr(input logic [10:0] a, input int n, input logic [7:0] d0,
      input logic dak);
    logic k;
    logic [3:0] p;
    p = a[3:0];
    mst_u.start();
    mst_u.wbyte({4'hA, a[10:8], 1'b0}, k);
    chk(k, 1'b1);
    mst_u.wbyte(a[7:0], k);
    chk(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst_u.wbyte(d0 + 8'(i), k);
      chk(k, dak);
      // Refused byte leaves the slot counter where it was
      if (dak) begin
        mem_m[{a[10:4], p}] = d0 + 8'(i);
        p++;
      end
    end
    cnt = {a[10:4], p};
    mst_u.stop();
    repeat (2) @(posedge sys_clk);
    #1;
    chk(prog_busy, dak && n > 0);
  endtask : wr

  task automatic rd(input logic [10:0] a, input int n);
    logic k;
    logic [7:0] b;
    mst_u.start();
    mst_u.wbyte({4'hA, a[10:8], 1'b1}, k);
    chk(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst_u.rbyte(i < n - 1, b);
      chk(b, mem_m[cnt]);
      cnt++;
    end
    mst_u.stop();
  endtask : rd

  task automatic poll(input logic [7:0] dv, input logic exp);
    logic k;
    mst_u.start();
    mst_u.wbyte(dv, k);
    chk(k, exp);
    mst_u.stop();
  endtask : poll

  // *********
  // Scenarios
  // *********
  task automatic t_page();
    wr(11'h5EE, 18, 8'h30, 1'b1);
    poll(8'hA0, 1'b0);
    wait_idle();
    poll(8'hA0, 1'b1);
    rd(11'h5E0, 16);
  endtask : t_page

  task automatic t_wrap();
    wr(11'h7FF, 1, 8'h5A, 1'b1);
    wait_idle();
    wr(11'h000, 1, 8'hA5, 1'b1);
    wait_idle();
    wr(11'h7FF, 0, 8'h00, 1'b1);
    rd(11'h7FF, 2);
  endtask : t_wrap

  // Protected write must leave the old byte
  task automatic t_protect();
    @(posedge sys_clk);
    #1 wp = 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(11'h000, 1, 8'h11, 1'b0);
    @(posedge sys_clk);
    #1 wp = 1'b0;
    repeat (4) @(posedge sys_clk);
    wr(11'h000, 0, 8'h00, 1'b1);
    rd(11'h000, 1);
  endtask : t_protect

  task automatic t_supervisor();
    @(posedge sys_clk);
    #1 sup_rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    poll(8'hA0, 1'b0);
    @(posedge sys_clk);
    #1 sup_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    poll(8'hA0, 1'b1);
  endtask : t_supervisor

  // Clear edge on reset so the bus-clocked flops are reset too
  task automatic t_reset();
    @(posedge sys_clk);
    #1 arst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk(sda_oe_n, 1'b1);
    chk(prog_busy, 1'b0);
    repeat (4) @(posedge sys_clk);
    poll(8'hB0, 1'b0);
    poll(8'hA0, 1'b1);
  endtask : t_reset

  // Reset during programming must end the busy time
  task automatic t_reset_mid();
    wr(11'h100, 1, 8'h77, 1'b1);
    t_reset();
  endtask : t_reset_mid

  initial begin
    t_reset();
    t_page();
    t_wrap();
    t_protect();
    t_supervisor();
    t_reset_mid();
    final_report();
  end
endmodule : ees_slave_tb
